// ---- hw/tx_pcs_pkg.sv ----
// Constants and types shared by the transmit PCS channel
package tx_pcs_pkg;
	localparam int MCLK_MHZ = 40;
	localparam int LOCK_TIME_NS = 1000;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam int LOCK_W = 6;
	localparam logic [LOCK_W-1:0] LOCK_CNT = LOCK_W'(LOCK_CYCLES);
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_FULL = 3'h4;
	localparam int FAB_W = 20;
	localparam int AXI_AW = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [31:0] CTRL_RST = 32'h00000041;
	localparam int PLLEN_POS = 0;
	localparam int DBL_POS = 1;
	localparam int WIDE10_POS = 2;
	localparam int BYP_POS = 3;
	localparam int PROTO_POS = 4;
	localparam int GSM_POS = 6;
	localparam int REFSEL_POS = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] LAST_BIT10 = 4'h9;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] RUN_MAX = 4'h5;
	localparam logic [6:0] PRBS_SEED = 7'h7F;
	localparam logic [4:0] A_MIN = 5'h10;
	localparam logic [4:0] A_MAX = 5'h1F;
	localparam logic [7:0] XG_IDLE = 8'h07;
	localparam logic [7:0] K28_0 = 8'h1C;
	localparam logic [7:0] K28_1 = 8'h3C;
	localparam logic [7:0] K28_3 = 8'h7C;
	localparam logic [7:0] K28_4 = 8'h9C;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] K28_6 = 8'hDC;
	localparam logic [7:0] K23_7 = 8'hF7;
	localparam logic [7:0] K27_7 = 8'hFB;
	localparam logic [7:0] K29_7 = 8'hFD;
	localparam logic [7:0] K30_7 = 8'hFE;
	localparam logic [7:0] D5_6 = 8'hC5;
	localparam logic [7:0] D16_2 = 8'h50;
	localparam logic [7:0] D21_5 = 8'hB5;
	localparam logic [7:0] D2_2 = 8'h42;
	localparam logic [4:0] K28_X = 5'h1C;
	localparam logic [4:0] D7_X = 5'h07;
	localparam logic [2:0] Y3 = 3'h3;
	localparam logic [2:0] Y7 = 3'h7;
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [3:0] A7_4B = 4'h7;
	localparam logic [5:0] ENC6_TAB [0:31] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] ENC4_TAB [0:7] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	typedef enum logic [1:0] {
		PROTO_BASIC = 2'h0,
		PROTO_GIGE  = 2'h1,
		PROTO_XAUI  = 2'h3
	} proto_type;
endpackage

// ---- hw/tx_pcs_channel.sv ----
// Transmit PCS channel: phase FIFO, byte serializer, idle mapping, 8B/10B, serializer
// Functional notes
// - Every word crosses a four-word phase FIFO; there is no bypass path.
// - Double width words leave as two single-width symbols, low half first.
// - Single width words go straight on without halving.
// - Encoder turns a byte plus control flag into a ten-bit code group.
// - Encoded serial stream never holds more than five equal bits in a row.
// - A control bit bypasses the encoder and sends raw symbols.
// - GIGE idle sets become comma plus D5.6 or comma plus D16.2.
// - Each GIGE idle set ends with negative running disparity.
// - Configuration sets (comma plus D21.5 or D2.2) pass untouched.
// - A control bit enables GIGE idle conversion while GIGE is selected.
// - XAUI control codes map to idle, sequence, start, terminate, error codes.
// - XAUI idles pick K28.0 or K28.5 from a seven-bit x^7+x^6+1 sequence.
// - XAUI inserts K28.3 after a random run of 16 to 31 idles.
// - Serializer sends each symbol least significant bit first.
// - One reference clock source select per block: pin, fabric, or shared line.
// - PLL yields serial, receiver and fabric timing; fabric rate halves in double width while words are queued.
// - The PLL may be powered down when no channel transmits.
// - A lock flag shows the PLL is locked to its reference.
`timescale 1ns/10ps
`default_nettype none
module tx_pcs_channel
(
	input  wire logic                           mclk,
	input  wire logic                           reset_n,
	input  wire logic [tx_pcs_pkg::AXI_AW-1:0]  awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic [1:0]                          bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [tx_pcs_pkg::AXI_AW-1:0]  araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	output logic                                rvalid,
	input  wire logic                           rready,
	input  wire logic [tx_pcs_pkg::FAB_W-1:0]   txData,
	input  wire logic [1:0]                     txCtrl,
	input  wire logic                           txValid,
	output logic                                txReady,
	output logic                                serialOut,
	output logic                                fabricTick,
	output logic [1:0]                          refClkSel,
	output logic                                pllPowerUp,
	output logic                                pllLocked
);
	import tx_pcs_pkg::*;
	typedef struct packed {
		logic [31:0]                  ctrl;
		logic [FIFO_DEPTH-1:0][21:0]  fifo;
		logic [1:0]                   wrPtr;
		logic [1:0]                   rdPtr;
		logic [2:0]                   cnt;
		logic                         txReady;
		logic [21:0]                  cur;
		logic                         halfPend;
		logic [3:0]                   bitCnt;
		logic [9:0]                   shift;
		logic                         serialOut;
		logic [3:0]                   runLen;
		logic                         encSym;
		logic                         rd;
		logic                         afterComma;
		logic [6:0]                   prbs;
		logic [4:0]                   aCnt;
		logic [LOCK_W-1:0]            lockCnt;
		logic                         locked;
		logic                         fabTick;
		logic                         awHave;
		logic                         wHave;
		logic [AXI_AW-1:0]            awAddr;
		logic [31:0]                  wData;
		logic [3:0]                   wStrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
	} state_type;
	localparam state_type ST_RST = '{
		ctrl:    CTRL_RST,
		bitCnt:  LAST_BIT10,
		prbs:    PRBS_SEED,
		aCnt:    A_MIN,
		default: '0};
	state_type  st_ff;
	state_type  nxt_st;
	logic       pllEn;
	logic       dbl;
	logic       wide10;
	logic       byp;
	logic       gsm;
	proto_type  proto;
	logic [3:0] lastBit;
	logic       push;
	logic       pop;
	logic       slotEnd;
	logic [9:0] raw10;
	logic [7:0] byteIn;
	logic       kIn;
	logic [7:0] mb;
	logic [10:0] encRes;
	logic [9:0] sym;
	logic       symLsb;
	logic       gigeRepl;
	logic       cfgSeen;
	logic       xIdle;
	logic       aInsert;
	logic [31:0] statWord;
	function automatic logic [10:0] enc8b10b
	(
		input logic [7:0] b,
		input logic       k,
		input logic       rdIn
	);
		logic [5:0] s6;
		logic [3:0] f4;
		logic       r1;
		logic       u4;
		logic [9:0] w;
		logic [9:0] o;
		s6 = (k && b[4:0] == K28_X) ? K28_6B : ENC6_TAB[b[4:0]];
		if (rdIn && (($countones(s6) != 3) || b[4:0] == D7_X))
			s6 = ~s6;
		r1 = rdIn ^ ($countones(s6) != 3);
		f4 = ENC4_TAB[b[7:5]];
		if (b[7:5] == Y7 && (k || (!r1 && s6[1:0] == 2'h3) || (r1 && s6[1:0] == 2'h0)))
			f4 = A7_4B;
		u4 = ($countones(f4) != 2);
		if (r1 && (u4 || b[7:5] == Y3))
			f4 = ~f4;
		if (k && !r1 && !u4 && b[7:5] != Y3)
			f4 = ~f4;
		w = {s6, f4};
		for (int i = 0; i < 10; i++)
			o[i] = w[9-i];
		return {r1 ^ u4, o};
	endfunction
	assign pllEn = st_ff.ctrl[PLLEN_POS];
	assign dbl = st_ff.ctrl[DBL_POS];
	assign wide10 = st_ff.ctrl[WIDE10_POS];
	assign byp = st_ff.ctrl[BYP_POS];
	assign gsm = st_ff.ctrl[GSM_POS];
	assign proto = proto_type'(st_ff.ctrl[PROTO_POS +: 2]);
	assign lastBit = (byp && !wide10) ? LAST_BIT8 : LAST_BIT10;
	assign symLsb = sym[0];
	assign statWord = {26'h0, (st_ff.cnt == 3'h0), st_ff.cnt, st_ff.rd, st_ff.locked};
	always_comb
	begin
		nxt_st = st_ff;
		pop = 1'b0;
		slotEnd = 1'b0;
		raw10 = '0;
		byteIn = '0;
		kIn = 1'b0;
		mb = '0;
		encRes = '0;
		sym = '0;
		gigeRepl = 1'b0;
		cfgSeen = 1'b0;
		xIdle = 1'b0;
		aInsert = 1'b0;
		nxt_st.fabTick = 1'b0;
		push = txValid && st_ff.txReady;
		// PLL power and lock model
		if (!pllEn)
		begin
			nxt_st.lockCnt = '0;
			nxt_st.locked = 1'b0;
		end
		else if (st_ff.lockCnt != LOCK_CNT)
			nxt_st.lockCnt = st_ff.lockCnt + 1'b1;
		else
			nxt_st.locked = 1'b1;
		// Bit timing, one serial bit per clock
		if (!st_ff.locked)
		begin
			nxt_st.bitCnt = lastBit;
			nxt_st.serialOut = 1'b0;
		end
		else
		begin
			slotEnd = (st_ff.bitCnt >= lastBit);
			nxt_st.bitCnt = slotEnd ? 4'h0 : st_ff.bitCnt + 4'h1;
			nxt_st.serialOut = st_ff.shift[0];
			nxt_st.shift = {1'b0, st_ff.shift[9:1]};
		end
		if (slotEnd)
		begin
			nxt_st.fabTick = !st_ff.halfPend;
			if (st_ff.halfPend)
			begin
				raw10 = wide10 ? st_ff.cur[19:10] : {2'h0, st_ff.cur[15:8]};
				byteIn = st_ff.cur[15:8];
				kIn = st_ff.cur[21];
				nxt_st.halfPend = 1'b0;
			end
			else if (st_ff.cnt != 3'h0)
			begin
				pop = 1'b1;
				nxt_st.cur = st_ff.fifo[st_ff.rdPtr];
				nxt_st.rdPtr = st_ff.rdPtr + 2'h1;
				nxt_st.halfPend = dbl;
				raw10 = wide10 ? st_ff.fifo[st_ff.rdPtr][9:0]
					: {2'h0, st_ff.fifo[st_ff.rdPtr][7:0]};
				byteIn = st_ff.fifo[st_ff.rdPtr][7:0];
				kIn = st_ff.fifo[st_ff.rdPtr][20];
			end
			else
			begin
				byteIn = (proto == PROTO_XAUI) ? XG_IDLE : K28_5;
				kIn = 1'b1;
			end
			mb = byteIn;
			if (proto == PROTO_XAUI && kIn)
			begin
				case (byteIn)
					XG_IDLE:
					begin
						xIdle = 1'b1;
						nxt_st.prbs = {st_ff.prbs[5:0], st_ff.prbs[6] ^ st_ff.prbs[5]};
						if (st_ff.aCnt == 5'h0)
						begin
							aInsert = 1'b1;
							mb = K28_3;
							nxt_st.aCnt = A_MIN + {1'b0, st_ff.prbs[3:0]};
						end
						else
						begin
							mb = st_ff.prbs[0] ? K28_5 : K28_0;
							nxt_st.aCnt = st_ff.aCnt - 5'h1;
						end
					end
					K28_4, K27_7, K29_7, K30_7, K28_0, K28_1, K28_3, K28_5, K28_6, K23_7:
						mb = byteIn;
					default:
						mb = K30_7;
				endcase
			end
			if (proto == PROTO_GIGE && gsm)
			begin
				cfgSeen = st_ff.afterComma && !kIn && (byteIn == D21_5 || byteIn == D2_2);
				if (st_ff.afterComma && !kIn && !cfgSeen)
				begin
					gigeRepl = 1'b1;
					mb = st_ff.rd ? D16_2 : D5_6;
				end
				nxt_st.afterComma = kIn && byteIn == K28_5;
			end
			else
				nxt_st.afterComma = 1'b0;
			encRes = enc8b10b(mb, kIn, st_ff.rd);
			if (!byp)
			begin
				sym = encRes[9:0];
				nxt_st.rd = encRes[10];
			end
			else
				sym = raw10;
			nxt_st.encSym = !byp;
			nxt_st.serialOut = sym[0];
			nxt_st.shift = {1'b0, sym[9:1]};
		end
		// Run of equal serial bits, counted over encoded symbols only
		if (!st_ff.locked || !nxt_st.encSym)
			nxt_st.runLen = 4'h0;
		else if (nxt_st.serialOut == st_ff.serialOut && st_ff.runLen != 4'h0)
			nxt_st.runLen = (st_ff.runLen == 4'hF) ? 4'hF : st_ff.runLen + 4'h1;
		else
			nxt_st.runLen = 4'h1;
		// Phase FIFO; the fabric side so one clock serves both sides
		if (push)
		begin
			nxt_st.fifo[st_ff.wrPtr] = {txCtrl, txData};
			nxt_st.wrPtr = st_ff.wrPtr + 2'h1;
		end
		nxt_st.cnt = st_ff.cnt + {2'h0, push} - {2'h0, pop};
		nxt_st.txReady = (nxt_st.cnt != FIFO_FULL);
		// Register write channel
		if (awvalid && st_ff.awready)
		begin
			nxt_st.awHave = 1'b1;
			nxt_st.awAddr = awaddr;
		end
		if (wvalid && st_ff.wready)
		begin
			nxt_st.wHave = 1'b1;
			nxt_st.wData = wdata;
			nxt_st.wStrb = wstrb;
		end
		if (st_ff.bvalid && bready)
			nxt_st.bvalid = 1'b0;
		if (nxt_st.awHave && nxt_st.wHave && !st_ff.bvalid)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.awHave = 1'b0;
			nxt_st.wHave = 1'b0;
			nxt_st.bresp = RESP_OKAY;
			if (nxt_st.awAddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2])
			begin
				for (int i = 0; i < 4; i++)
					if (nxt_st.wStrb[i])
						nxt_st.ctrl[i*8 +: 8] = nxt_st.wData[i*8 +: 8];
			end
			else if (nxt_st.awAddr[AXI_AW-1:2] != STAT_OFS[AXI_AW-1:2])
				nxt_st.bresp = RESP_SLVERR;
		end
		nxt_st.awready = !nxt_st.awHave && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.wHave && !nxt_st.bvalid;
		// Register read channel
		if (st_ff.rvalid && rready)
			nxt_st.rvalid = 1'b0;
		if (arvalid && st_ff.arready)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			if (araddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2])
				nxt_st.rdata = st_ff.ctrl;
			else if (araddr[AXI_AW-1:2] == STAT_OFS[AXI_AW-1:2])
				nxt_st.rdata = statWord;
			else
			begin
				nxt_st.rdata = '0;
				nxt_st.rresp = RESP_SLVERR;
			end
		end
		nxt_st.arready = !nxt_st.rvalid;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign txReady = st_ff.txReady;
	assign serialOut = st_ff.serialOut;
	assign fabricTick = st_ff.fabTick;
	assign refClkSel = st_ff.ctrl[REFSEL_POS +: 2];
	assign pllPowerUp = st_ff.ctrl[PLLEN_POS];
	assign pllLocked = st_ff.locked;
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	AST_FIFO_FULL: assert property (st_ff.cnt == FIFO_FULL |-> !txReady && !push)
		else $error("fifo full but still accepting");
	AST_FIFO_BOUND: assert property (st_ff.cnt <= FIFO_FULL)
		else $error("fifo count beyond depth");
	AST_DOUBLE_SPLIT: assert property (pop && dbl |=> st_ff.halfPend && !pop)
		else $error("double word not split into two symbols");
	AST_SINGLE_DIRECT: assert property (pop && !dbl |=> !st_ff.halfPend)
		else $error("single word held for a second half");
	AST_RUN_MAX: assert property (st_ff.locked && st_ff.encSym |-> st_ff.runLen <= RUN_MAX)
		else $error("run of equal bits longer than five");
	AST_BYPASS_RD: assert property (slotEnd && byp |=> st_ff.rd == $past(st_ff.rd))
		else $error("disparity moved while encoder bypassed");
	AST_GIGE_NEG: assert property (gigeRepl |=> !st_ff.rd)
		else $error("idle set did not end negative");
	AST_GIGE_CFG: assert property (cfgSeen |-> !gigeRepl)
		else $error("configuration set was converted");
	AST_XAUI_A: assert property (aInsert |=> st_ff.aCnt >= A_MIN && st_ff.aCnt <= A_MAX)
		else $error("alignment spacing outside 16 to 31");
	AST_PRBS_STEP: assert property (xIdle |=> st_ff.prbs != $past(st_ff.prbs) && st_ff.prbs != 7'h00)
		else $error("idle sequence did not advance");
	AST_LSB_FIRST: assert property (slotEnd |=> serialOut == $past(symLsb))
		else $error("symbol not sent least significant bit first");
	AST_PLL_OFF: assert property (!pllPowerUp |=> !pllLocked ##1 !pllLocked || pllPowerUp)
		else $error("lock shown while pll powered down");

	COV_DOUBLE: cover property (pop && dbl ##[1:40] pop);
	COV_GIGE_IDLE: cover property (gigeRepl && st_ff.rd);
	COV_XAUI_ALIGN: cover property (aInsert);
	COV_CFG_PASS: cover property (cfgSeen);
endmodule
`default_nettype wire

// ---- testbench/fabric_source.sv ----
// Fabric-side word source that feeds the transmit channel
`timescale 1ns/10ps
`default_nettype none
module fabric_source
(
	input  wire logic                         mclk,
	input  wire logic                         txReady,
	output logic [tx_pcs_pkg::FAB_W-1:0]      txData,
	output logic [1:0]                        txCtrl,
	output logic                              txValid
);
	import tx_pcs_pkg::*;
	initial
	begin
		txData = '0;
		txCtrl = 2'h0;
		txValid = 1'b0;
	end
	// Offer a word on mclk itself and hold it until taken
	task automatic push(input logic [FAB_W-1:0] d, input logic [1:0] c);
		txData <= d;
		txCtrl <= c;
		txValid <= 1'b1;
		do @(posedge mclk); while (txReady !== 1'b1);
	endtask
	// Release: lines show the inverse of the last word
	task automatic idle();
		txValid <= 1'b0;
		txData <= ~txData;
		txCtrl <= ~txCtrl;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ---- testbench/serial_transceiver_tx_pcs_test.sv ----
// Self-checking bench for the transmit PCS channel
`timescale 1ns/10ps
`default_nettype none
module serial_transceiver_tx_pcs_test;
	import tx_pcs_pkg::*;
	logic mclk = 1'b0, reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, txReady, txValid;
	logic serialOut, fabricTick, pllPowerUp, pllLocked, mon = 1'b0, last;
	logic [1:0] bresp, rresp, refClkSel, txCtrl, r;
	logic [FAB_W-1:0] txData;
	logic [9:0] p, s;
	int err_count = 0, comparisons = 0, cyc = 0, nb = 10, run = 0, gap, nr, nk, na;
	logic [7:0] xd [6] = '{8'hFB, 8'h9C, 8'hFD, 8'hFE, 8'h00, 8'hC5};
	logic [9:0] xa [6] = '{10'h05B, 10'h13C, 10'h05D, 10'h05E, 10'h05E, 10'h1A5};
	logic [9:0] xb [6] = '{10'h3A4, 10'h2C3, 10'h3A2, 10'h3A1, 10'h3A1, 10'h1A5};
	tx_pcs_channel i_tx_pcs_channel (.mclk(mclk), .reset_n(reset_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .txData(txData), .txCtrl(txCtrl), .txValid(txValid),
		.txReady(txReady), .serialOut(serialOut), .fabricTick(fabricTick),
		.refClkSel(refClkSel), .pllPowerUp(pllPowerUp), .pllLocked(pllLocked));
	fabric_source i_fabric_source (.mclk(mclk), .txReady(txReady), .txData(txData),
		.txCtrl(txCtrl), .txValid(txValid));
	always #12.5 mclk = ~mclk;
	task automatic finish_test();
		$display("err_count %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	// Run-length watch on the encoded line
	always @(negedge mclk)
		if (mon)
		begin
			run = (serialOut === last) ? run + 1 : 1;
			last = serialOut;
			if (run > 5)
			begin
				chk("run length", 5, run);
				mon = 1'b0;
			end
		end
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit ta, tw;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ta = 0;
		tw = 0;
		do
		begin
			@(posedge mclk);
			if (!ta && awready === 1'b1)
			begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (!tw && wready === 1'b1)
			begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end
		while (!(ta && tw));
		while (bvalid !== 1'b1) @(posedge mclk);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge mclk);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic sym(output logic [9:0] v);
		v = 10'h000;
		for (int i = 0; i < nb; i++)
		begin
			v[i] = serialOut;
			@(negedge mclk);
		end
	endtask
	function automatic bit filler(int m, logic [9:0] v);
		if (m == 0)
			return v === 10'h000;
		return v === 10'h17C || v === 10'h283 || (m == 2 && (v === 10'h0BC ||
			v === 10'h343 || v === 10'h33C || v === 10'h0C3));
	endfunction
	// Align to a symbol start, then skip filler symbols
	task automatic find(input int m);
		do @(negedge mclk); while (fabricTick !== 1'b1);
		sym(s);
		p = s;
		repeat (60)
			if (filler(m, s))
			begin
				p = s;
				sym(s);
			end
	endtask
	// Watch the line while the pair is queued, so the comma is never missed
	task automatic gige(input logic [7:0] b);
		fork
			begin
				i_fabric_source.push(20'h000BC, 2'h1);
				i_fabric_source.push({12'h000, b}, 2'h0);
				i_fabric_source.idle();
			end
			find(1);
		join
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk("pllPowerUp", 1, pllPowerUp);
		chk("refClkSel", 0, refClkSel);
		chk("pllLocked", 0, pllLocked);
		repeat (4) i_fabric_source.push(20'h00000, 2'h0);
		i_fabric_source.idle();
		chk("txReady full", 0, txReady);
		rd(STAT_OFS, d, r);
		chk("fifo count", 4, d[4:2]);
		repeat (60) if (pllLocked !== 1'b1) @(posedge mclk);
		chk("pllLocked", 1, pllLocked);
		rd(CTRL_OFS, d, r);
		chk("ctrl reset", CTRL_RST, d);
		rd(8'h08, d, r);
		chk("unmapped rresp", RESP_SLVERR, r);
		chk("unmapped rdata", 0, d);
		wr(8'h08, 32'h0000FFFF, r);
		chk("unmapped bresp", RESP_SLVERR, r);
		wr(STAT_OFS, 32'h00000000, r);
		chk("status write", RESP_OKAY, r);
		rd(STAT_OFS, d, r);
		chk("status locked", 1, d[0]);
		repeat (60) @(posedge mclk);
		do @(negedge mclk); while (fabricTick !== 1'b1);
		sym(p);
		sym(s);
		chk("filler", (p === 10'h17C) ? 10'h283 : 10'h17C, s);
		mon = 1'b1;
		for (int i = 0; i < 16; i++) i_fabric_source.push(20'(i * 17), 2'h0);
		i_fabric_source.idle();
		repeat (200) @(posedge mclk);
		mon = 1'b0;
		wr(CTRL_OFS, 32'h00000009, r);
		nb = 8;
		i_fabric_source.push(20'h000A5, 2'h0);
		i_fabric_source.idle();
		find(0);
		chk("bypass byte", 10'h0A5, s);
		wr(CTRL_OFS, 32'h0000000B, r);
		i_fabric_source.push(20'h03C5A, 2'h0);
		i_fabric_source.idle();
		find(0);
		chk("low half", 10'h05A, s);
		chk("half tick", 0, fabricTick);
		sym(s);
		chk("high half", 10'h03C, s);
		wr(CTRL_OFS, 32'h0000000D, r);
		nb = 10;
		i_fabric_source.push(20'h002B7, 2'h0);
		i_fabric_source.idle();
		find(0);
		chk("raw ten bit", 10'h2B7, s);
		wr(CTRL_OFS, 32'h00000051, r);
		gige(8'h00);
		chk("idle second", (p === 10'h283) ? 10'h1A5 : 10'h289, s);
		chk("idle comma", (p === 10'h17C) ? 10'h17C : 10'h283, p);
		gige(D21_5);
		chk("config set", 10'h155, s);
		wr(CTRL_OFS, 32'h00000011, r);
		gige(8'h00);
		chk("unconverted", (p === 10'h17C) ? 10'h346 : 10'h0B9, s);
		wr(CTRL_OFS, 32'h00000031, r);
		repeat (30) @(posedge mclk);
		do @(negedge mclk); while (fabricTick !== 1'b1);
		gap = 0;
		nr = 0;
		nk = 0;
		na = 0;
		repeat (120)
		begin
			sym(s);
			chk("xaui idle", filler(2, s), 1);
			if (s === 10'h0BC || s === 10'h343)
				nr++;
			if (s === 10'h17C || s === 10'h283)
				nk++;
			if (s === 10'h33C || s === 10'h0C3)
			begin
				if (na > 0)
					chk("idle gap", (gap >= 16 && gap <= 31) ? gap : 16, gap);
				na++;
				gap = 0;
			end
			else
				gap++;
		end
		chk("K28.0 seen", 1, nr > 0);
		chk("K28.5 seen", 1, nk > 0);
		chk("K28.3 seen", 1, na > 1);
		for (int i = 0; i < 6; i++)
		begin
			i_fabric_source.push({12'h000, xd[i]}, {1'b0, i < 5});
			i_fabric_source.idle();
			find(2);
			chk("xaui code", (s === xb[i]) ? xb[i] : xa[i], s);
		end
		wr(CTRL_OFS, 32'h00000200, r);
		@(posedge mclk);
		chk("pll off", 0, pllPowerUp);
		chk("ref select", 2, refClkSel);
		repeat (3) @(posedge mclk);
		chk("unlocked", 0, pllLocked);
		finish_test();
	end
endmodule
`default_nettype wire
